// ==== bench/pcrb_regs_asserts.sv ====
// Checker: bus handshake, read data and sampling window relations of the counter bank
`timescale 1ns/10ps
`default_nettype none

module pcrb_regs_asserts
	import pcrb_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCRB_AW-1:0] paddr,
	input wire logic [PCRB_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [PCRB_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic hot_swap_strap,
	input wire logic sampling_active
);
	// ====
	// Decode helpers
	logic acc, rd_setup, mapped, wr_timer;
	assign acc = psel && penable;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped = paddr inside {[8'h7C:8'h9C]} && paddr[1:0] == 2'h0 || paddr inside {8'hB0, 8'hC0};
	assign wr_timer = acc && pwrite && paddr == PCRB_OFF_TIMER && pstrb == 4'hF;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ====
	// Assertions
	chk_ready_access: assert property (pready == acc) else $error("pready not tied to access");
	chk_err_unmapped: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
	chk_err_rdata: assert property (rd_setup && !mapped |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!rd_setup |=> $stable(prdata)) else $error("prdata moved");
	chk_hs_entry: assert property (rd_setup && paddr == PCRB_OFF_HS_CAP |=> prdata == 32'h6)
		else $error("hot swap entry wrong");
	chk_slot_fixed: assert property (rd_setup && paddr == PCRB_OFF_SLOT_CAP |=>
		prdata[23:0] == {2'h0, 6'(prdata[21:16]), hot_swap_strap ? 8'hC0 : 8'h00, 8'h04})
		else $error("slot entry fixed fields wrong");
	chk_window_open: assert property (wr_timer && pwdata != 32'h0 |=> sampling_active)
		else $error("window not opened");
	chk_window_len: assert property (wr_timer && pwdata == 32'h4 |=>
		sampling_active [*4] ##1 !sampling_active) else $error("window length wrong");
	chk_window_stop: assert property (wr_timer && pwdata == 32'h0 |=> !sampling_active)
		else $error("window not stopped");
	chk_reset_idle: assert property ($rose(nrst) |-> !sampling_active && prdata == 32'h0)
		else $error("reset state wrong");
endmodule // pcrb_regs_asserts

bind pcrb_regs pcrb_regs_asserts i_chk (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .hot_swap_strap(hot_swap_strap),
	.sampling_active(sampling_active));
`default_nettype wire

// ==== bench/pcrb_regs_tb_top.sv ====
// Testbench: APB access, counters and capability entries of the counter bank
`timescale 1ns/10ps
`default_nettype none

module pcrb_regs_tb_top;
	import pcrb_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, strap = 1'b1;
	logic [7:0] paddr = 8'h00, ev = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic pready, pslverr, sampling_active, err;
	int mismatches = 0;
	int total_checks = 0;

	pcrb_regs i_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sec_io_rd_done(ev[0]), .sec_io_wr_done(ev[1]),
		.sec_mem_rd_done(ev[2]), .sec_mem_wr_done(ev[3]), .pri_io_rd_done(ev[4]),
		.pri_io_wr_done(ev[5]), .pri_mem_rd_done(ev[6]), .pri_mem_wr_done(ev[7]),
		.hot_swap_strap(strap), .sampling_active(sampling_active));

	// Clock at 40 MHz
	initial
	begin
		forever #12.5 clk = ~clk;
	end

	// ====
	// Tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// Master waits for pready without assuming latency; an idle cycle follows
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// No latency is assumed; only the watchdog ends a hung access
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask

	// Counter i sees i+1 back-to-back pulses
	task pulse();
		for (int n = 0; n < 8; n++)
		begin
			ev <= 8'hFF << n;
			@(posedge clk);
		end
		ev <= 8'h00;
		@(posedge clk);
	endtask

	task end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog at 5000 cycles, far beyond the roughly 140 cycles the sequence needs
	initial
	begin
		#125000;
		mismatches++;
		end_of_test();
	end

	// ====
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) rdc("cnt_rst", 8'h80 + 8'(4 * i), 32'h0);
		rdc("slot_rst", PCRB_OFF_SLOT_CAP, 32'h0000C004);
		rdc("hs_cap", PCRB_OFF_HS_CAP, 32'h00000006);
		pulse();
		rdc("cnt_idle", 8'h9C, 32'h0);
		apb(1'b1, 8'h94, 32'hFFFFFFF0);
		apb(1'b1, PCRB_OFF_TIMER, 32'd100);
		pulse();
		apb(1'b1, PCRB_OFF_TIMER, 32'h0);
		pulse();
		for (int i = 0; i < 8; i++) rdc("cnt", 8'h80 + 8'(4 * i), (i == 5) ? 32'hFFFFFFF6 : 32'(i + 1));
		apb(1'b1, PCRB_OFF_TIMER, 32'h4);
		chk("active_on", 32'h1, {31'h0, sampling_active});
		repeat (8) @(posedge clk);
		chk("active", 32'h0, {31'h0, sampling_active});
		apb(1'b1, PCRB_OFF_SLOT_CAP, 32'hFFFFFFFF);
		rdc("slot_rw", PCRB_OFF_SLOT_CAP, 32'hFF3FC004);
		apb(1'b1, PCRB_OFF_HS_CAP, 32'hFFFFFFFF);
		rdc("hs_ro", PCRB_OFF_HS_CAP, 32'h00000006);
		rdc("unmapped", 8'hA0, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		strap <= 1'b0;
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rdc("slot_nohs", PCRB_OFF_SLOT_CAP, 32'h00000004);
		rdc("cnt_rst2", 8'h84, 32'h0);
		end_of_test();
	end
endmodule // pcrb_regs_tb_top
`default_nettype wire

// ==== src/pcrb_pkg.sv ====
// Package: map, field layout and reset values of the performance counter bank
package pcrb_pkg;

	// ==========================================================
	// Bus widths and sizes
	localparam int PCRB_AW = 8;
	localparam int PCRB_DW = 32;
	localparam int PCRB_NUM_CNT = 8;
	localparam int PCRB_IDX_W = 3;
	localparam logic [3:0] PCRB_STRB_ALL = 4'hF;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] PCRB_OFF_TIMER = 8'h7C;
	localparam logic [7:0] PCRB_OFF_SEC_IO_RD = 8'h80;
	localparam logic [7:0] PCRB_OFF_SEC_IO_WR = 8'h84;
	localparam logic [7:0] PCRB_OFF_SEC_MEM_RD = 8'h88;
	localparam logic [7:0] PCRB_OFF_SEC_MEM_WR = 8'h8C;
	localparam logic [7:0] PCRB_OFF_PRI_IO_RD = 8'h90;
	localparam logic [7:0] PCRB_OFF_PRI_IO_WR = 8'h94;
	localparam logic [7:0] PCRB_OFF_PRI_MEM_RD = 8'h98;
	localparam logic [7:0] PCRB_OFF_PRI_MEM_WR = 8'h9C;
	localparam logic [7:0] PCRB_OFF_SLOT_CAP = 8'hB0;
	localparam logic [7:0] PCRB_OFF_HS_CAP = 8'hC0;

	// ==========================================================
	// Field positions inside the capability entries
	localparam int PCRB_CAPID_LSB = 0;
	localparam int PCRB_NEXT_LSB = 8;
	localparam int PCRB_SLOTNUM_LSB = 16;
	localparam int PCRB_SLOTNUM_W = 5;
	localparam int PCRB_FIRST_BIT = 21;
	localparam int PCRB_RSVD_LSB = 22;
	localparam int PCRB_CHASSIS_LSB = 24;

	// ==========================================================
	// Constant field values
	localparam logic [7:0] PCRB_SLOT_CAP_ID = 8'h04;
	localparam logic [7:0] PCRB_NEXT_WITH_HS = 8'hC0;
	localparam logic [7:0] PCRB_NEXT_NO_HS = 8'h00;
	localparam logic [7:0] PCRB_HS_CAP_ID = 8'h06;
	localparam logic [7:0] PCRB_HS_NEXT = 8'h00;
	localparam logic [1:0] PCRB_RSVD_VAL = 2'h0;

	// ==========================================================
	// Reset values
	localparam logic [31:0] PCRB_CNT_RESET = 32'h0000_0000;
	localparam logic [31:0] PCRB_TIMER_RESET = 32'h0000_0000;
	localparam logic [4:0] PCRB_SLOTNUM_RESET = 5'h00;
	localparam logic PCRB_FIRST_RESET = 1'b0;
	localparam logic [7:0] PCRB_CHASSIS_RESET = 8'h00;
	localparam logic [31:0] PCRB_RDATA_RESET = 32'h0000_0000;

	// ==========================================================
	// State of the sampling timer
	typedef struct packed {
		logic [31:0] remain;
		logic active;
	} pcrb_timer_st_t;

	// State of the register bank
	typedef struct packed {
		logic [PCRB_NUM_CNT-1:0][31:0] cnt;
		logic [4:0] slot_num;
		logic first_in_chassis;
		logic [7:0] chassis_num;
		logic strap;
		logic [31:0] rdata;
	} pcrb_regs_st_t;

endpackage

// ==== src/pcrb_regs.sv ====
// Performance counter and capability list register bank, APB slave
//
// Functional notes
// RQ1 - Secondary I/O write count at 84h
// RQ2 - Secondary memory read count at 88h
// RQ3 - Secondary memory write count at 8Ch
// RQ4 - Primary I/O read count at 90h
// RQ5 - Primary I/O write count at 94h
// RQ6 - Primary memory read count at 98h
// RQ7 - Primary memory write count at 9Ch
// RQ8 - Counters advance only while sampling; reset zero
// RQ9 - Nonzero timer write starts window; expiry ends
// RQ10 - Slot entry next pointer follows hot-swap strap
// RQ11 - Five-bit slot number, read/write, bits 20:16
// RQ12 - First-in-chassis flag, read/write, bit 21
// RQ13 - Bits 23:22 read zero, writes ignored
// RQ14 - Hot-swap entry identifier reads 06h
// RQ15 - Hot-swap entry next pointer reads 00h
// RQ16 - Chassis number, read/write, bits 31:24
// RQ17 - Counter write replaces value, counting continues
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module pcrb_regs
	import pcrb_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PCRB_AW-1:0] paddr,
	input wire logic [PCRB_DW-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [PCRB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Successful transaction completions, one-cycle pulses
	input wire logic sec_io_rd_done,
	input wire logic sec_io_wr_done,
	input wire logic sec_mem_rd_done,
	input wire logic sec_mem_wr_done,
	input wire logic pri_io_rd_done,
	input wire logic pri_io_wr_done,
	input wire logic pri_mem_rd_done,
	input wire logic pri_mem_wr_done,
	// Board strap enabling the hot-swap capability
	input wire logic hot_swap_strap,
	// Sampling window open
	output logic sampling_active
);

	// ==========================================================
	// Helper functions

	// True when the offset falls on one of the eight counters
	function automatic logic is_counter(input logic [PCRB_AW-1:0] a);
		is_counter = (a >= PCRB_OFF_SEC_IO_RD) && (a <= PCRB_OFF_PRI_MEM_WR)
			&& (a[1:0] == 2'h0);
	endfunction

	// Counter index from the offset, word step from the first counter
	function automatic logic [PCRB_IDX_W-1:0] counter_idx(
		input logic [PCRB_AW-1:0] a);
		logic [PCRB_AW-1:0] d;
		d = a - PCRB_OFF_SEC_IO_RD;
		counter_idx = d[PCRB_IDX_W+1:2];
	endfunction

	// True for any offset that the bank answers
	function automatic logic is_mapped(input logic [PCRB_AW-1:0] a);
		is_mapped = is_counter(a) || (a == PCRB_OFF_TIMER)
			|| (a == PCRB_OFF_SLOT_CAP) || (a == PCRB_OFF_HS_CAP);
	endfunction

	// Byte-lane merge of write data over the old contents
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_val;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				r[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		merge_bytes = r;
	endfunction

	// ==========================================================
	// State and internal signals
	pcrb_regs_st_t st_reg;
	pcrb_regs_st_t st_next;
	logic [PCRB_NUM_CNT-1:0] ev_vec;
	logic setup_phase;
	logic access_phase;
	logic wr_take;
	logic wr_timer;
	logic [31:0] timer_remain;
	logic timer_active;
	logic [31:0] timer_wdata;
	logic [7:0] slot_next_ptr;
	logic [31:0] slot_word;
	logic [31:0] hs_word;
	logic [31:0] slot_wdata;

	// ==========================================================
	// Event gathering, index order follows the counter offsets
	// RQ1 secondary I/O writes
	// RQ2 secondary memory reads
	// RQ3 secondary memory writes
	// RQ4 primary I/O reads
	// RQ5 primary I/O writes
	// RQ6 primary memory reads
	// RQ7 primary memory writes
	assign ev_vec = {pri_mem_wr_done, pri_mem_rd_done,
		pri_io_wr_done, pri_io_rd_done,
		sec_mem_wr_done, sec_mem_rd_done,
		sec_io_wr_done, sec_io_rd_done};

	// ==========================================================
	// APB phase decode; zero wait states, so pready is always high in access
	assign setup_phase = psel && !penable;
	assign access_phase = psel && penable;
	assign wr_take = access_phase && pwrite && is_mapped(paddr);
	assign pready = access_phase;
	// Unmapped offsets answer with an error and change nothing
	assign pslverr = access_phase && !is_mapped(paddr);
	assign prdata = st_reg.rdata;

	// ==========================================================
	// Sampling timer
	// RQ9 nonzero write starts
	assign wr_timer = wr_take && (paddr == PCRB_OFF_TIMER);
	assign timer_wdata = merge_bytes(timer_remain, pwdata, pstrb);

	pcrb_sample_timer u_timer (
		.clk(clk),
		.nrst(nrst),
		.load(wr_timer),
		.load_value(timer_wdata),
		.remain(timer_remain),
		.active(timer_active)
	);

	assign sampling_active = timer_active;

	// ==========================================================
	// Capability entry words
	// RQ10 strap selects pointer
	assign slot_next_ptr = st_reg.strap ? PCRB_NEXT_WITH_HS : PCRB_NEXT_NO_HS;

	// RQ13 reserved reads zero
	assign slot_word = {st_reg.chassis_num, PCRB_RSVD_VAL,
		st_reg.first_in_chassis, st_reg.slot_num,
		slot_next_ptr, PCRB_SLOT_CAP_ID};

	// RQ14 hot-swap identifier
	// RQ15 end of list
	// Hot-swap control bits live elsewhere, so the upper half reads zero here
	assign hs_word = {16'h0000, PCRB_HS_NEXT, PCRB_HS_CAP_ID};

	assign slot_wdata = merge_bytes(slot_word, pwdata, pstrb);

	// ==========================================================
	// Next-state logic of the bank, reset included (synchronous)
	always_comb
	begin
		st_next = st_reg;
		if (!nrst)
		begin
			// RQ8 counters reset zero
			for (int i = 0; i < PCRB_NUM_CNT; i++)
			begin
				st_next.cnt[i] = PCRB_CNT_RESET;
			end
			st_next.slot_num = PCRB_SLOTNUM_RESET;
			st_next.first_in_chassis = PCRB_FIRST_RESET;
			st_next.chassis_num = PCRB_CHASSIS_RESET;
			st_next.rdata = PCRB_RDATA_RESET;
			// Strap is caught by the clock while reset is held
			st_next.strap = hot_swap_strap;
		end
		else
		begin
			// RQ1 to RQ7 and RQ17: counters, software write wins
			for (int i = 0; i < PCRB_NUM_CNT; i++)
			begin
				// RQ17 write replaces count
				if (wr_take && is_counter(paddr)
					&& (counter_idx(paddr) == PCRB_IDX_W'(i)))
				begin
					st_next.cnt[i] = merge_bytes(st_reg.cnt[i], pwdata, pstrb);
				end
				// RQ8 count only while sampling
				else if (timer_active && ev_vec[i])
				begin
					st_next.cnt[i] = st_reg.cnt[i] + 32'h0000_0001;
				end
			end

			// Slot identification entry fields
			if (wr_take && (paddr == PCRB_OFF_SLOT_CAP))
			begin
				// RQ11 slot number write
				st_next.slot_num = slot_wdata[PCRB_SLOTNUM_LSB +: PCRB_SLOTNUM_W];
				// RQ12 first-in-chassis write
				st_next.first_in_chassis = slot_wdata[PCRB_FIRST_BIT];
				// RQ16 chassis number write
				st_next.chassis_num = slot_wdata[PCRB_CHASSIS_LSB +: 8];
			end

			// Read data is latched in setup, so prdata is a flop in access
			if (setup_phase && !pwrite)
			begin
				st_next.rdata = PCRB_RDATA_RESET;
				if (is_counter(paddr))
				begin
					st_next.rdata = st_reg.cnt[counter_idx(paddr)];
				end
				else if (paddr == PCRB_OFF_TIMER)
				begin
					st_next.rdata = timer_remain;
				end
				else if (paddr == PCRB_OFF_SLOT_CAP)
				begin
					st_next.rdata = slot_word;
				end
				else if (paddr == PCRB_OFF_HS_CAP)
				begin
					st_next.rdata = hs_word;
				end
			end
		end
	end

	// ==========================================================
	// Register the state copy
	always_ff @(posedge clk)
	begin
		st_reg <= st_next;
	end

endmodule // pcrb_regs

`default_nettype wire

// ==== src/pcrb_sample_timer.sv ====
// Sampling timer: loadable down-counter that opens the counting window
`timescale 1ns/10ps
`default_nettype none

module pcrb_sample_timer
	import pcrb_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic load,
	input wire logic [31:0] load_value,
	output logic [31:0] remain,
	output logic active
);

	// ==========================================================
	// State
	pcrb_timer_st_t st_reg;
	pcrb_timer_st_t st_next;

	// Next state: a write reloads the timer, otherwise count down while active
	always_comb
	begin
		st_next = st_reg;
		if (!nrst)
		begin
			st_next.remain = PCRB_TIMER_RESET;
			st_next.active = 1'b0;
		end
		else if (load)
		begin
			// A nonzero write starts sampling at the next edge
			st_next.remain = load_value;
			st_next.active = (load_value != PCRB_TIMER_RESET);
		end
		else if (st_reg.active)
		begin
			// Active stays a flop so counters see a glitch-free window
			st_next.remain = st_reg.remain - 32'h0000_0001;
			st_next.active = (st_reg.remain != 32'h0000_0001);
		end
	end

	// Register the state copy
	always_ff @(posedge clk)
	begin
		st_reg <= st_next;
	end

	// Outputs straight from flops
	assign remain = st_reg.remain;
	assign active = st_reg.active;

endmodule // pcrb_sample_timer

`default_nettype wire
